/* hdl/mssl_defines.svh */
// register offsets, reset values, function codes and timing counts
`ifndef MSSL_DEFINES_SVH
`define MSSL_DEFINES_SVH
`define MSSL_A_STOP     4'h0
`define MSSL_A_CODE0    4'h1
`define MSSL_A_EXT      4'h6
`define MSSL_A_STAT     4'h7
`define MSSL_RST_STOP   14'h270F
`define MSSL_RST_EXT    14'h0000
`define MSSL_STOP_RAMPA 14'h270F
`define MSSL_STOP_RAMPB 14'h22B8
`define MSSL_STOP_CMAX  14'h0064
`define MSSL_STOP_BLO   14'h03E8
`define MSSL_STOP_BHI   14'h044C
`define MSSL_FC_FWD     14'h003C
`define MSSL_FC_REV     14'h003D
`define MSSL_FC_LOW     14'h0000
`define MSSL_FC_MID     14'h0001
`define MSSL_FC_HIGH    14'h0002
`define MSSL_FC_JOG     14'h0005
`define MSSL_CLK_HZ     25000000
`define MSSL_UNIT_S     1
`define MSSL_SEC_CYC    (`MSSL_UNIT_S * `MSSL_CLK_HZ)
`endif

/* hdl/mssl_pkg.sv */
// types shared by the stop and start selection block
package mssl_pkg;
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } mssl_req_t;
    typedef struct packed {
        logic run;
        logic fwd;
        logic decel;
        logic restart;
    } mssl_cmd_t;
    typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_DECEL, ST_DELAY, ST_COAST} mssl_state_t;
endpackage

/* hdl/mssl_stop_start.sv */
// stop method and start input selection for a motor drive
// Operation
// - setting 9999 or 8888: ramp down when start command withdrawn
// - setting 0..100: cut output that many seconds after start off
// - setting 1000..1100: cut output after setting minus 1000 seconds
// - settings 1000..1100 or 8888: first input runs, second picks direction
// - running indication drops when output is cut for coasting
// - power-fail, panel, comm-error stop or jog override stop method
// - other settings: keep tracking frequency until start off and cut; this block ramps them down instead, like 9999
// - start during coasting restarts from the starting frequency
// - each terminal has own function code; defaults 60,61,0,1,2
// - stop and code settings writable only while display selection is 0
// - same code on several terminals: function active if any is
// - terminal changes answered within 20 ms
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "mssl_defines.svh"
module mssl_stop_start
    import mssl_pkg::*;
#(
    parameter int SEC_CYC = `MSSL_SEC_CYC
)
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire mssl_req_t  busReq,
    output logic [15:0]     rdData_r,
    input  wire logic [4:0] termPins,
    input  wire logic       powerFailStop,
    input  wire logic       panelStop,
    input  wire logic       commErrStop,
    input  wire logic       rampDone,
    input  wire logic       motorStopped,
    output mssl_cmd_t       driveCmd_r,
    output logic [2:0]      speedSel_r,
    output logic            jogActive_r
);
    logic [4:0]  sync1_r, sync2_r, sync3_r, termLvl_r;
    logic [13:0] termCode_r [5];
    logic [13:0] stopSet_r, extDisp_r;
    logic        fFwd_r, fRev_r;
    logic        modeB, rampStop, startOn, dirFwd, override, secHit, tick;
    logic [6:0]  delaySet, delay_r, secCnt_r;
    logic [31:0] tickCnt_r;
    mssl_state_t state_r, stateNxt;
    mssl_cmd_t   cmdNxt;

    // function active when any terminal carrying that code is active
    function automatic logic funcOn(input logic [13:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 5; i++)
            hit = hit | (termLvl_r[i] & (termCode_r[i] == code));
        return hit;
    endfunction

    // three-stage pin sampling, level taken once stages two and three agree
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync1_r   <= 5'h00;
            sync2_r   <= 5'h00;
            sync3_r   <= 5'h00;
            termLvl_r <= 5'h00;
        end
        else
        begin
            sync1_r <= termPins;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            for (int i = 0; i < 5; i++)
                if (sync2_r[i] == sync3_r[i])
                    termLvl_r[i] <= sync3_r[i];
        end
    end

    // per-terminal function code, writes locked by the display selection
    for (genvar g = 0; g < 5; g++)
    begin : gCode
        localparam logic [13:0] CODE_RST = (g == 0) ? `MSSL_FC_FWD :
                                           (g == 1) ? `MSSL_FC_REV :
                                           (g == 2) ? `MSSL_FC_LOW :
                                           (g == 3) ? `MSSL_FC_MID : `MSSL_FC_HIGH;
        always_ff @(posedge clk or negedge rst_b)
        begin
            if (!rst_b)
                termCode_r[g] <= CODE_RST;
            else if (busReq.wr && busReq.addr == `MSSL_A_CODE0 + 4'(g)
                     && extDisp_r == 14'h0000)
                termCode_r[g] <= busReq.wdata[13:0];
        end
    end

    // stop setting and display selection
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stopSet_r <= `MSSL_RST_STOP;
            extDisp_r <= `MSSL_RST_EXT;
        end
        else if (busReq.wr)
        begin
            if (busReq.addr == `MSSL_A_STOP && extDisp_r == 14'h0000)
                stopSet_r <= busReq.wdata[13:0];
            else if (busReq.addr == `MSSL_A_EXT)
                extDisp_r <= busReq.wdata[13:0];
        end
    end

    // read port, data one cycle after the strobe, unmapped reads zero
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rdData_r <= 16'h0000;
        else if (!busReq.rd)
            rdData_r <= 16'h0000;
        else if (busReq.addr == `MSSL_A_STOP)
            rdData_r <= {2'h0, stopSet_r};
        else if (busReq.addr >= `MSSL_A_CODE0 && busReq.addr < `MSSL_A_EXT)
            rdData_r <= {2'h0, termCode_r[3'(busReq.addr - `MSSL_A_CODE0)]};
        else if (busReq.addr == `MSSL_A_EXT)
            rdData_r <= {2'h0, extDisp_r};
        else if (busReq.addr == `MSSL_A_STAT)
            rdData_r <= {4'h0, termLvl_r, startOn, dirFwd, secHit, 1'b0, state_r};
        else
            rdData_r <= 16'h0000;
    end

    // decoded terminal functions, one cycle behind the levels
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fFwd_r      <= 1'b0;
            fRev_r      <= 1'b0;
            speedSel_r  <= 3'h0;
            jogActive_r <= 1'b0;
        end
        else
        begin
            fFwd_r      <= funcOn(`MSSL_FC_FWD);
            fRev_r      <= funcOn(`MSSL_FC_REV);
            speedSel_r  <= {funcOn(`MSSL_FC_HIGH), funcOn(`MSSL_FC_MID),
                            funcOn(`MSSL_FC_LOW)};
            jogActive_r <= funcOn(`MSSL_FC_JOG);
        end
    end

    // stop setting decode and start input interpretation
    always_comb
    begin
        modeB    = (stopSet_r == `MSSL_STOP_RAMPB) ||
                   (stopSet_r >= `MSSL_STOP_BLO && stopSet_r <= `MSSL_STOP_BHI);
        // undefined settings fall back to ramping, the safer stop
        rampStop = !((stopSet_r <= `MSSL_STOP_CMAX) ||
                     (stopSet_r >= `MSSL_STOP_BLO && stopSet_r <= `MSSL_STOP_BHI));
        delaySet = modeB ? 7'(stopSet_r - `MSSL_STOP_BLO) : 7'(stopSet_r);
        if (modeB)
        begin
            startOn = fFwd_r;
            dirFwd  = !fRev_r;
        end
        else
        begin
            // both inputs on counts as no start
            startOn = fFwd_r ^ fRev_r;
            dirFwd  = fFwd_r;
        end
        override = powerFailStop | panelStop | commErrStop | jogActive_r;
        tick     = (tickCnt_r == 32'(SEC_CYC - 1));
        secHit   = (secCnt_r == delay_r);
    end

    // stop sequencer next state
    always_comb
    begin
        stateNxt = state_r;
        case (state_r)
            ST_IDLE:
                if (startOn)
                    stateNxt = ST_RUN;
            ST_RUN:
                if (!startOn)
                begin
                    if (override || rampStop)
                        stateNxt = ST_DECEL;
                    else if (delaySet == 7'h00)
                        stateNxt = ST_COAST;
                    else
                        stateNxt = ST_DELAY;
                end
            ST_DECEL:
                if (startOn)
                    stateNxt = ST_RUN;
                else if (rampDone)
                    stateNxt = ST_IDLE;
            ST_DELAY:
                if (startOn)
                    stateNxt = ST_RUN;
                else if (override)
                    stateNxt = ST_DECEL;
                else if (secHit)
                    stateNxt = ST_COAST;
            ST_COAST:
                if (startOn)
                    stateNxt = ST_RUN;
                else if (motorStopped)
                    stateNxt = ST_IDLE;
            default:
                stateNxt = ST_IDLE;
        endcase
        cmdNxt.run     = (stateNxt == ST_RUN) || (stateNxt == ST_DECEL) ||
                         (stateNxt == ST_DELAY);
        cmdNxt.decel   = (stateNxt == ST_DECEL);
        cmdNxt.fwd     = startOn ? dirFwd : driveCmd_r.fwd;
        cmdNxt.restart = (stateNxt == ST_RUN) &&
                         (state_r == ST_IDLE || state_r == ST_COAST);
    end

    // state and drive commands move together
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r    <= ST_IDLE;
            driveCmd_r <= '0;
        end
        else
        begin
            state_r    <= stateNxt;
            driveCmd_r <= cmdNxt;
        end
    end

    // coast delay: latched at start off, seconds from a cycle divider
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            delay_r   <= 7'h00;
            secCnt_r  <= 7'h00;
            tickCnt_r <= 32'h0000_0000;
        end
        else if (state_r != ST_DELAY || stateNxt != ST_DELAY)
        begin
            // any exit, including a new start, clears the timer
            secCnt_r  <= 7'h00;
            tickCnt_r <= 32'h0000_0000;
            if (state_r == ST_RUN)
                delay_r <= delaySet;
        end
        else if (tick)
        begin
            tickCnt_r <= 32'h0000_0000;
            secCnt_r  <= secCnt_r + 7'h01;
        end
        else
            tickCnt_r <= tickCnt_r + 32'h0000_0001;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence sRunStopOff;
        state_r == ST_RUN && !startOn;
    endsequence
    sequence sCoastStart;
        state_r == ST_COAST && startOn;
    endsequence

    a_ramp_on_off:     assert property (sRunStopOff ##0 rampStop |=> state_r == ST_DECEL)
        else $error("ramp setting did not decelerate");
    a_coast_cut_time:  assert property (state_r == ST_DELAY && secHit && !startOn && !override
                           |=> state_r == ST_COAST && !driveCmd_r.run)
        else $error("output not cut at delay end");
    a_offset_delay:    assert property (sRunStopOff ##0 !override && !rampStop && modeB
                           |=> delay_r == 7'(stopSet_r - `MSSL_STOP_BLO))
        else $error("offset delay wrong");
    a_sep_starts:      assert property (!modeB && fRev_r && !fFwd_r |-> startOn && !dirFwd)
        else $error("reverse start not decoded");
    a_start_dir:       assert property (modeB |-> startOn == fFwd_r && dirFwd == !fRev_r)
        else $error("start with direction not decoded");
    a_run_drops:       assert property (state_r == ST_COAST |-> !driveCmd_r.run)
        else $error("run shown while coasting");
    a_override_decel:  assert property (sRunStopOff ##0 override |=> driveCmd_r.decel)
        else $error("override did not decelerate");
    a_track_delay:     assert property (state_r == ST_DELAY
                           |-> driveCmd_r.run && !driveCmd_r.decel)
        else $error("not tracking during delay");
    a_coast_restart:   assert property (sCoastStart |=> driveCmd_r.restart ##1 !driveCmd_r.restart)
        else $error("no restart from coasting");
    a_write_lock:      assert property (busReq.wr && busReq.addr == `MSSL_A_STOP
                           && extDisp_r != 14'h0000 |=> $stable(stopSet_r))
        else $error("stop setting changed while locked");
    a_or_terms:        assert property (termLvl_r[3] && termCode_r[3] == `MSSL_FC_HIGH
                           |=> speedSel_r[2])
        else $error("shared code not ored");
    a_pin_response:    assert property ($stable(termPins)[*5] |-> termLvl_r == termPins)
        else $error("pin level not taken");
    a_timer_clear:     assert property (state_r == ST_DELAY && startOn
                           |=> state_r == ST_RUN && secCnt_r == 7'h00)
        else $error("delay timer not cleared");
endmodule

/* tb/mssl_partner_model.sv */
// far-side model: terminal switches and motor mechanics
`timescale 1ns/100ps
module mssl_partner_model
    import mssl_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [4:0] wantPins,
    input  wire logic [7:0] rampLen,
    input  wire mssl_cmd_t  driveCmd,
    output logic [4:0]      termPins,
    output logic            rampDone,
    output logic            motorStopped
);
    logic [7:0] rampCnt_r;
    logic [7:0] coastCnt_r;

    // switches move just after the edge, like a real contact bank
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            termPins <= 5'h00;
        else
            termPins <= wantPins;

    // ramp length varies so the drive sees prompt and slow motors
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
            rampCnt_r <= 8'h00;
            coastCnt_r <= 8'h00;
            rampDone <= 1'b0;
            motorStopped <= 1'b0;
        end
        else
        begin
            rampCnt_r <= driveCmd.decel ? rampCnt_r + 8'h01 : 8'h00;
            rampDone <= driveCmd.decel && (rampCnt_r >= rampLen);
            // a coasting motor needs rampLen cycles to come to rest
            if (driveCmd.run)
                coastCnt_r <= 8'h00;
            else if (coastCnt_r != 8'hFF)
                coastCnt_r <= coastCnt_r + 8'h01;
            motorStopped <= !driveCmd.run && (coastCnt_r >= rampLen);
        end
endmodule

/* tb/mssl_stop_start_test.sv */
// testbench for the stop method and start input selection block
`timescale 1ns/100ps
module mssl_stop_start_test
    import mssl_pkg::*;
;
    localparam int SEC = 10;
    logic       clk;
    logic       rst_b;
    mssl_req_t  busReq;
    logic [15:0] rdData_r;
    logic [4:0] wantPins;
    logic [4:0] termPins;
    logic       powerFailStop;
    logic       panelStop;
    logic       commErrStop;
    logic       rampDone;
    logic       motorStopped;
    mssl_cmd_t  driveCmd_r;
    logic [2:0] speedSel_r;
    logic       jogActive_r;
    logic [7:0] rampLen;
    int         fail_count;
    int         checks;
    int         cyc;
    int         seed;
    int         regs[8];

    // clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    mssl_stop_start #(.SEC_CYC(SEC)) i_mssl_stop_start (.clk(clk), .rst_b(rst_b),
        .busReq(busReq), .rdData_r(rdData_r), .termPins(termPins),
        .powerFailStop(powerFailStop), .panelStop(panelStop), .commErrStop(commErrStop),
        .rampDone(rampDone), .motorStopped(motorStopped), .driveCmd_r(driveCmd_r),
        .speedSel_r(speedSel_r), .jogActive_r(jogActive_r));
    mssl_partner_model i_mssl_partner_model (.clk(clk), .rst_b(rst_b),
        .wantPins(wantPins), .rampLen(rampLen), .driveCmd(driveCmd_r),
        .termPins(termPins), .rampDone(rampDone), .motorStopped(motorStopped));

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // bus cycles leave one idle cycle so no strobe is driven twice per step
    task automatic wr(input logic [3:0] a, input int d);
        busReq <= '{a, d[15:0], 1'b1, 1'b0};
        @(posedge clk);
        busReq <= '0;
        if ((a < 6 && regs[6] == 0) || a == 6)
            regs[a] = d;
        @(posedge clk);
    endtask

    task automatic rd(input logic [3:0] a);
        busReq <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge clk);
        busReq <= '0;
        #1;
        chk(rdData_r, (a < 7) ? regs[a][15:0] : 16'h0000, "read");
        @(posedge clk);
    endtask

    // start on pins p, release, then judge ramp or timed coast
    task automatic stop_case(input int s, input logic [4:0] p, input logic f, input logic o);
        int d;
        int n;
        int pulses;
        logic sawDecel;
        d = (s <= 100) ? s : (s >= 1000 && s <= 1100) ? s - 1000 : -1;
        wr(0, s);
        wantPins <= p;
        pulses = 0;
        repeat (8)
        begin
            @(negedge clk);
            pulses += driveCmd_r.restart;
        end
        chk(driveCmd_r.run, 1'b1, "run");
        chk(driveCmd_r.fwd, f, "direction");
        chk(16'(pulses), 16'h0001, "restart pulse");
        @(posedge clk);
        wantPins <= p & 5'h1C; // only the start terminals are released
        n = 0;
        sawDecel = 1'b0;
        while (driveCmd_r.run !== 1'b0 && n < 2000)
        begin
            @(negedge clk);
            n++;
            sawDecel |= driveCmd_r.decel;
        end
        @(posedge clk);
        if (d < 0 || o)
            chk(sawDecel, 1'b1, "ramp down");
        else
        begin
            chk(sawDecel, 1'b0, "coast");
            chk(n >= d * SEC && n <= d * SEC + 12, 1'b1, "delay");
        end
        $display("test stop %0d done", s);
    endtask

    // hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            print_verdict;
        end
    end

    initial
    begin
        int i;
        int n;
        logic ok;
        busReq = '0;
        wantPins = 5'h00;
        {powerFailStop, panelStop, commErrStop} = 3'b000;
        rampLen = 8'h05;
        rst_b = 1'b0;
        seed = 29;
        regs = '{9999, 60, 61, 0, 1, 2, 0, 0};
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 7; i++)
            rd(4'(i));
        rd(4'h9);
        wr(6, 1);
        wr(0, 5);
        rd(0);
        wr(6, 0);
        rd(6);
        $display("test registers done");
        stop_case(9999, 5'h01, 1'b1, 1'b0);
        stop_case(9999, 5'h02, 1'b0, 1'b0);
        stop_case(8888, 5'h03, 1'b0, 1'b0);
        stop_case(8888, 5'h01, 1'b1, 1'b0);
        stop_case(0, 5'h02, 1'b0, 1'b0);
        rampLen <= 8'($unsigned($random(seed)) % 40);
        stop_case(1 + $unsigned($random(seed)) % 6, 5'h01, 1'b1, 1'b0);
        stop_case(1000 + $unsigned($random(seed)) % 11, 5'h03, 1'b0, 1'b0);
        // start again inside the delay keeps the output on; delay long enough
        rampLen <= 8'hC8;
        wr(0, 1005);
        wantPins <= 5'h01;
        repeat (10) @(posedge clk);
        wantPins <= 5'h00;
        repeat (20) @(posedge clk);
        wantPins <= 5'h01;
        ok = 1'b1;
        n = 0;
        repeat (80)
        begin
            @(negedge clk);
            ok &= driveCmd_r.run;
            n += driveCmd_r.restart;
        end
        chk(ok, 1'b1, "held run");
        chk(16'(n), 16'h0000, "no restart");
        @(posedge clk);
        wantPins <= 5'h00;
        repeat (120) @(posedge clk);
        chk(driveCmd_r.run, 1'b0, "late cut");
        // start while the motor still coasts restarts from the starting frequency
        wantPins <= 5'h01;
        n = 0;
        repeat (8)
        begin
            @(negedge clk);
            n += driveCmd_r.restart;
        end
        chk(16'(n), 16'h0001, "coast restart");
        chk(driveCmd_r.run, 1'b1, "coast run");
        @(posedge clk);
        wantPins <= 5'h00;
        repeat (300) @(posedge clk);
        chk(driveCmd_r.run, 1'b0, "coast done");
        // shared codes and jog
        wr(4, 2);
        wr(3, 5);
        wantPins <= 5'h0C;
        repeat (8) @(posedge clk);
        chk(speedSel_r, 3'h4, "shared code");
        chk(jogActive_r, 1'b1, "jog");
        stop_case(3, 5'h0D, 1'b1, 1'b1);
        wr(3, 0);
        wr(4, 1);
        for (i = 0; i < 3; i++)
        begin
            {powerFailStop, panelStop, commErrStop} <= 3'(3'b100 >> i);
            stop_case(1003, 5'h01, 1'b1, 1'b1);
        end
        {powerFailStop, panelStop, commErrStop} <= 3'b000;
        print_verdict;
    end
endmodule
